/* oes_defines.svh */
// oes_defines.svh: constants for the two-wire serial memory slave
// assumes inclusion by bare name from the package and design files
`ifndef OES_DEFINES_SVH
`define OES_DEFINES_SVH
// select type code: the value is arbitrary and stands in for a maker's code
`define OES_TYPE_ID      4'h6
`define OES_ADDR_W       9
`define OES_MEM_DEPTH    512
`define OES_ID_MSB       7
`define OES_ID_LSB       4
`define OES_BLOCK_BIT    1
`define OES_RW_BIT       0
`define OES_PAGE_MASK    9'h00f
`define OES_BITS_PER_BYT 4'h8
`endif

/* oes_eeprom_slave.sv */
// oes_eeprom_slave.sv: serial memory slave holding distance totals
// assumes bus lines synchronous to clk and a master slower than clk/4
// How it works
// - slave only; every action is paced by master clock edges or by start and stop conditions.
// - select byte with direction bit follows start; slave acknowledges it.
// - only select bytes carrying the fixed 4-bit type code are answered.
// - on writes, slave drives acknowledge in ninth bit after each byte.
// - protect input high blocks every array write.
`timescale 1ns/100ps
`default_nettype none
`include "oes_defines.svh"
module oes_eeprom_slave
  import oes_pkg::*;
#(
  parameter int         ADDR_W  = `OES_ADDR_W,
  parameter int         DEPTH   = `OES_MEM_DEPTH,
  parameter logic [3:0] TYPE_ID = `OES_TYPE_ID // arbitrary value, no real maker's code
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic scl,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  input  wire logic write_protect_input,
  output logic      busBusy,
  output logic      writeRefused
);
  // block bit plus word byte need at least nine address bits and a full array
  if (DEPTH != (1 << ADDR_W) || ADDR_W < 9) begin : g_bad_geometry
    $error("depth must be 2**ADDR_W with ADDR_W >= 9");
  end

  oes_evt_t   evt;
  oes_state_t state;
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic       selected;
  logic       readMode;
  logic       firstByte;
  logic       haveAddr;
  logic [ADDR_W-1:0] addr;
  logic [7:0] mem [DEPTH];
  logic       memWr;
  logic [7:0] rdByte;

  oes_line_edges u_edges (
    .clk    (clk),
    .arst_n (arst_n),
    .scl    (scl),
    .sda    (sdaIn),
    .evt    (evt)
  );

  assign rdByte = mem[addr];

  // array commit at the close of an acknowledged data byte
  assign memWr    = (state == OES_ACK) && evt.sclFall && selected && !readMode
                    && !firstByte && haveAddr && !write_protect_input;

  // phase machine, every step on a master clock edge or a start or stop condition
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= OES_IDLE;
      bitCnt    <= 4'h0;
      shiftReg  <= 8'h00;
      selected  <= 1'b0;
      readMode  <= 1'b0;
      firstByte <= 1'b0;
      haveAddr  <= 1'b0;
    end else if (evt.start) begin
      state     <= OES_RXBIT;
      bitCnt    <= 4'h0;
      selected  <= 1'b0;
      firstByte <= 1'b1;
      haveAddr  <= 1'b0;
    end else if (evt.stop) begin
      state    <= OES_IDLE;
      selected <= 1'b0;
    end else begin
      case (state)
        OES_RXBIT: begin
          if (evt.sclRise) begin
            shiftReg <= {shiftReg[6:0], evt.sdaLevel};
            bitCnt   <= bitCnt + 4'h1;
          end
          if (evt.sclFall && bitCnt == `OES_BITS_PER_BYT) begin
            bitCnt <= 4'h0;
            if (firstByte) begin
              // select byte: compare type code, take direction bit
              if (shiftReg[`OES_ID_MSB:`OES_ID_LSB] == TYPE_ID) begin
                selected <= 1'b1;
                readMode <= shiftReg[`OES_RW_BIT];
                state    <= OES_ACK;
              end else begin
                state <= OES_WAIT;
              end
            end else begin
              state <= OES_ACK;
            end
          end
        end
        OES_ACK: begin
          if (evt.sclFall) begin
            firstByte <= 1'b0;
            if (!firstByte) haveAddr <= 1'b1;
            state <= readMode ? OES_TXBIT : OES_RXBIT;
          end
        end
        OES_TXBIT: begin
          if (evt.sclFall) begin
            bitCnt <= bitCnt + 4'h1;
            if (bitCnt == 4'h7) begin
              bitCnt <= 4'h0;
              state  <= OES_MACK;
            end
          end
        end
        OES_MACK: begin
          // master no-ack ends the read stream until the next start
          if (evt.sclRise && evt.sdaLevel) state <= OES_WAIT;
          else if (evt.sclFall) state <= OES_TXBIT;
        end
        OES_WAIT: state <= OES_WAIT;
        default:  state <= OES_IDLE;
      endcase
    end
  end

  // address: block bit from select byte, word from first written byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr <= '0;
    end else if (state == OES_ACK && evt.sclFall && firstByte) begin
      addr[ADDR_W-1] <= shiftReg[`OES_BLOCK_BIT];
    end else if (state == OES_ACK && evt.sclFall && !readMode && !haveAddr) begin
      addr[7:0] <= shiftReg;
    end else if (memWr) begin
      // page roll within the low address bits
      addr[3:0] <= addr[3:0] + 4'h1;
    end else if (state == OES_MACK && evt.sclFall) begin
      addr <= addr + 1'b1;
    end
  end

  // storage array, flip-flops indexed by address
  always_ff @(posedge clk) begin
    if (memWr) mem[addr] <= shiftReg;
  end

  // refused write flag for the current transfer; set wins over start clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) writeRefused <= 1'b0;
    else if ((state == OES_ACK) && evt.sclFall && selected && !readMode
             && !firstByte && haveAddr && write_protect_input) writeRefused <= 1'b1;
    else if (evt.start) writeRefused <= 1'b0;
  end

  // data line drive: ack low in ninth bit, read bits msb first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdaOut <= 1'b1;
      sdaOe  <= 1'b0;
    end else if (evt.start || evt.stop) begin
      sdaOut <= 1'b1;
      sdaOe  <= 1'b0;
    end else if (state == OES_RXBIT && evt.sclFall && bitCnt == `OES_BITS_PER_BYT
                 && (!firstByte || shiftReg[`OES_ID_MSB:`OES_ID_LSB] == TYPE_ID)) begin
      sdaOut <= 1'b0;
      sdaOe  <= 1'b1;
    end else if ((state == OES_ACK && evt.sclFall && readMode)
                 || (state == OES_TXBIT && evt.sclFall && bitCnt != 4'h7)) begin
      sdaOut <= rdByte[3'(4'h7 - (state == OES_ACK ? 4'h0 : bitCnt + 4'h1))];
      sdaOe  <= 1'b1;
    end else if ((state == OES_ACK && evt.sclFall)
                 || (state == OES_TXBIT && evt.sclFall)) begin
      sdaOut <= 1'b1;
      sdaOe  <= 1'b0; // release after a write-byte ack, or for master acknowledge
    end else if (state == OES_MACK && evt.sclFall && !evt.sdaLevel) begin
      sdaOut <= mem[addr + 1'b1][7];
      sdaOe  <= 1'b1;
    end
  end

  // busy between start and stop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) busBusy <= 1'b0;
    else if (evt.start) busBusy <= 1'b1;
    else if (evt.stop) busBusy <= 1'b0;
  end

  property p_ack_after_byte;
    @(posedge clk) disable iff (!arst_n)
      (state == OES_RXBIT && !firstByte && evt.sclFall && bitCnt == 4'h8 && !evt.start)
      |=> (sdaOe && !sdaOut);
  endproperty
  a_ack_after_byte: assert property (p_ack_after_byte) else $error("no ack");

  property p_protect_blocks;
    @(posedge clk) disable iff (!arst_n)
      write_protect_input |-> !memWr;
  endproperty
  a_protect_blocks: assert property (p_protect_blocks) else $error("protected write");

  property p_foreign_id;
    @(posedge clk) disable iff (!arst_n)
      (state == OES_RXBIT && firstByte && evt.sclFall && bitCnt == 4'h8
       && shiftReg[`OES_ID_MSB:`OES_ID_LSB] != TYPE_ID && !evt.start && !evt.stop)
      |=> !selected && !sdaOe;
  endproperty
  a_foreign_id: assert property (p_foreign_id) else $error("foreign id answered");

  property p_select_ack;
    @(posedge clk) disable iff (!arst_n)
      $rose(selected) |-> sdaOe && !sdaOut;
  endproperty
  a_select_ack: assert property (p_select_ack) else $error("select not acked");

  property p_idle_release;
    @(posedge clk) disable iff (!arst_n)
      evt.start |=> !sdaOe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("drive after start");
endmodule // oes_eeprom_slave
`default_nettype wire

/* oes_eeprom_slave_tb.sv */
// oes_eeprom_slave_tb.sv: self-checking bench for the serial memory slave
// assumes oes_master_model drives the bus; data line is wired-and with pull-up
`timescale 1ns/100ps
`default_nettype none
`define OES_CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin badCount++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module oes_eeprom_slave_tb;
  import oes_pkg::*;
  logic clk;
  logic arst_n;
  logic scl, sdaPull, sdaOut, sdaOe, wp, busBusy, writeRefused;
  wire logic sda;
  int badCount = 0;
  int checksDone = 0;
  // open-drain line: low when anyone pulls
  assign sda = ~(sdaPull | (sdaOe & ~sdaOut));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  oes_master_model mdl (.clk(clk), .sda(sda), .scl(scl), .sdaPull(sdaPull),
    .write_protect_input(wp));
  oes_eeprom_slave uut (.clk(clk), .arst_n(arst_n), .scl(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .write_protect_input(wp),
    .busBusy(busBusy), .writeRefused(writeRefused));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // select, word address, two bytes; protect opened only around the write
  task automatic t_save();
    logic a;
    mdl.protect(1'b0);
    mdl.start();
    mdl.send(8'h60, a); `OES_CHK(a, 1'b1)
    mdl.send(8'h10, a); `OES_CHK(a, 1'b1)
    `OES_CHK(busBusy, 1'b1)
    mdl.send(8'h5a, a); `OES_CHK(a, 1'b1)
    mdl.send(8'h3c, a); `OES_CHK(a, 1'b1)
    mdl.stop();
    mdl.protect(1'b1);
    `OES_CHK(busBusy, 1'b0)
    `OES_CHK(writeRefused, 1'b0)
  endtask
  // set address then repeated start into a read of both bytes
  task automatic t_read(input logic [7:0] first);
    logic a;
    logic [7:0] d;
    mdl.start();
    mdl.send(8'h60, a);
    mdl.send(8'h10, a);
    mdl.start();
    mdl.send(8'h61, a); `OES_CHK(a, 1'b1)
    mdl.recv(1'b0, d); `OES_CHK(d, first)
    mdl.recv(1'b1, d); `OES_CHK(d, 8'h3c)
    mdl.stop();
  endtask
  // five foreign type codes in the top nibble must be ignored
  task automatic t_foreign();
    logic a;
    logic [7:0] codes [5] = '{8'h20, 8'h50, 8'h70, 8'hb0, 8'he1};
    foreach (codes[i]) begin
      mdl.start();
      mdl.send(codes[i], a); `OES_CHK(a, 1'b0)
      mdl.stop();
    end
  endtask
  // protect high: byte acked but refused, contents kept, flag cleared by a start
  task automatic t_protect();
    logic a;
    logic [7:0] d;
    mdl.start();
    mdl.send(8'h60, a);
    mdl.send(8'h10, a);
    mdl.send(8'hff, a); `OES_CHK(a, 1'b1)
    mdl.stop();
    `OES_CHK(writeRefused, 1'b1)
    t_read(8'h5a);
    `OES_CHK(writeRefused, 1'b0)
    // read with no address starts at the last byte address the read reached
    mdl.start();
    mdl.send(8'h61, a); `OES_CHK(a, 1'b1)
    mdl.recv(1'b1, d); `OES_CHK(d, 8'h3c)
    mdl.stop();
  endtask
  // reset in mid-transfer drops the bus state at once; the bus is then closed
  task automatic t_reset();
    logic a;
    mdl.start();
    mdl.send(8'h60, a); `OES_CHK(a, 1'b1)
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    `OES_CHK(busBusy, 1'b0)
    `OES_CHK(sdaOe, 1'b0)
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `OES_CHK(sdaOe, 1'b0)
    mdl.stop();
  endtask
  // hang guard well past the few thousand clocks the tests need
  initial begin
    repeat (40000) @(posedge clk);
    badCount++;
    wrap_up();
  end
  initial begin
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `OES_CHK(sdaOe, 1'b0)
    `OES_CHK(sdaOut, 1'b1)
    `OES_CHK(busBusy, 1'b0)
    `OES_CHK(writeRefused, 1'b0)
    t_save();
    t_read(8'h5a);
    t_reset();
    t_foreign();
    t_protect();
    wrap_up();
  end
endmodule // oes_eeprom_slave_tb
`default_nettype wire

/* oes_line_edges.sv */
// oes_line_edges.sv: edge and framing detector on the two bus lines
// assumes scl and sda already synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module oes_line_edges
  import oes_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic scl,
  input  wire logic sda,
  output oes_evt_t  evt
);
  logic sclQ;
  logic sdaQ;
  // previous levels for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
    end
  end
  // start: data falls with clock high; stop: data rises with clock high
  always_comb begin
    evt.start    = sclQ && scl && sdaQ && !sda;
    evt.stop     = sclQ && scl && !sdaQ && sda;
    evt.sclRise  = !sclQ && scl;
    evt.sclFall  = sclQ && !scl;
    evt.sdaLevel = sda;
  end
endmodule // oes_line_edges
`default_nettype wire

/* oes_master_model.sv */
// oes_master_model.sv: bit-banged two-wire bus master standing in for the host
// assumes a pull-up on the data line, resolved by the bench from all pulls
`timescale 1ns/100ps
`default_nettype none
module oes_master_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaPull,
  output logic      write_protect_input
);
  // idle bus, array guarded until a write is meant
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
    write_protect_input = 1'b1;
  end
  // every line change is a port pin toggle held six clocks, above the four needed
  task automatic go(input logic c, input logic p);
    scl <= c;
    sdaPull <= p;
    repeat (6) @(posedge clk);
  endtask
  task automatic protect(input logic v);
    write_protect_input <= v;
    repeat (2) @(posedge clk);
  endtask
  // start, also usable as a repeated start from a low clock
  task automatic start();
    go(scl, 1'b0);
    go(1'b1, 1'b0);
    go(1'b1, 1'b1);
    go(1'b0, 1'b1);
  endtask
  task automatic stop();
    go(1'b0, 1'b1);
    go(1'b1, 1'b1);
    go(1'b1, 1'b0);
  endtask
  task automatic put_bit(input logic b);
    go(1'b0, ~b);
    go(1'b1, ~b);
    go(1'b0, ~b);
  endtask
  task automatic get_bit(output logic b);
    go(1'b0, 1'b0);
    go(1'b1, 1'b0);
    b = sda;
    go(1'b0, 1'b0);
  endtask
  // msb first, then the slave answers in the ninth bit
  task automatic send(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask
  // last byte of a read is left unacknowledged
  task automatic recv(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
endmodule // oes_master_model
`default_nettype wire

/* oes_pkg.sv */
// oes_pkg.sv: types for the two-wire serial memory slave
// assumes oes_defines.svh is on the include path
`default_nettype none
`include "oes_defines.svh"
package oes_pkg;
  // bus slave phases, one-hot
  typedef enum logic [5:0] {
    OES_IDLE  = 6'h01,
    OES_RXBIT = 6'h02,
    OES_ACK   = 6'h04,
    OES_TXBIT = 6'h08,
    OES_MACK  = 6'h10,
    OES_WAIT  = 6'h20
  } oes_state_t;
  // sampled line events from the edge detector
  typedef struct packed {
    logic start;
    logic stop;
    logic sclRise;
    logic sclFall;
    logic sdaLevel;
  } oes_evt_t;
endpackage
`default_nettype wire
